// >>> scp_pkg.sv
// Package: shared constants and types for the serial channel pin and pointer block
// Summary of operation
// - Channel 0 data and primary clock pins stay serial; other one-way pins may be GPIO (the code reads all six channel 1 pins as GPIO, none of channel 0).
// - Primary-clock receive with NRZ/NRZI samples data on the deasserting clock edge.
// - FM coding with external receive clock samples data on both clock edges.
// - A control bit swaps the primary clock input for the system clock at the baud input.
// - Secondary-clock transmit with NRZ/NRZI changes data on the deasserting edge.
// - FM coding with secondary transmit clock changes data on both edges.
// - Secondary clock as output drives transmit clock, baud input clock or PLL input clock.
// - In async mode the sync pin is an input that only updates the sync status bit.
// - Internal sync: the device drives sync low when a sync or flag character is seen.
// - Auto-handshake: transmitter runs only while clear-to-send is low.
// - Async auto-handshake: request-to-send is low while the transmitter is not empty.
// - Auto-handshake: receiver runs only while carrier-detect is low.
// - Terminal-ready output follows a software-written control bit.
// - Internal registers are reached by a pointer write then one read or write.
// - Data port read gives receive FIFO, write loads transmit FIFO, no pointer needed.
// - Single-byte accesses on data bits 7:0; bits 31:8 ignored; big-endian adds 0x3.
// - A read of the shared reset address resets both channels.
// - Pointer 0x02 is the vector on channel 1 only; channel 0 reads zero, ignores writes.
// - Read pointers decode to status, pending, receive FIFO, clock status, baud, enable.
// - Write pointers decode to reset, enables, control, mode, sync, FIFO, clock, baud.
// - After the access following a pointer write, the pointer returns to zero.
// - A data-register read removes the read entry from the receive FIFO.
package scp_pkg;
   localparam logic [31:0] ADDR_PTR1  = 32'hffffe800;
   localparam logic [31:0] ADDR_DATA1 = 32'hffffe804;
   localparam logic [31:0] ADDR_PTR0  = 32'hffffe808;
   localparam logic [31:0] ADDR_DATA0 = 32'hffffe80c;
   localparam logic [31:0] ADDR_RESET = 32'hffffe810;
   localparam int          FIFO_DEPTH = 16;
   localparam int          FIFO_WIDTH = 8;

   // Pointer numbers
   localparam logic [3:0] P_STAT_LO = 4'h0;
   localparam logic [3:0] P_STAT_HI = 4'h1;
   localparam logic [3:0] P_VECTOR  = 4'h2;
   localparam logic [3:0] P_PEND    = 4'h3;
   localparam logic [3:0] P_MODE_LO = 4'h4;
   localparam logic [3:0] P_TXCTL   = 4'h5;
   localparam logic [3:0] P_SYNC_LO = 4'h6;
   localparam logic [3:0] P_SYNC_HI = 4'h7;
   localparam logic [3:0] P_FIFO    = 4'h8;
   localparam logic [3:0] P_CHRST   = 4'h9;
   localparam logic [3:0] P_MODE_HI = 4'ha;
   localparam logic [3:0] P_CLKCTL  = 4'hb;
   localparam logic [3:0] P_BAUD_LO = 4'hc;
   localparam logic [3:0] P_BAUD_HI = 4'hd;
   localparam logic [3:0] P_PLLCTL  = 4'he;
   localparam logic [3:0] P_IEN_HI  = 4'hf;

   // Field positions
   localparam int MODE_CODE_LSB = 0;  // Low mode [1:0] coding
   localparam int MODE_SYNC_LSB = 2;  // Low mode [3:2] sync mode
   localparam int MODE_AUTOHS   = 4;  // Low mode bit 4 auto handshake
   localparam int MODE_DTR      = 5;  // Low mode bit 5 terminal ready
   localparam int CLK_BAUD_SYS  = 0;  // Clock control bit 0
   localparam int CLK_RX_PRI    = 1;
   localparam int CLK_TX_SEC    = 2;
   localparam int CLK_SEC_OUT   = 3;
   localparam int CLK_SEC_LSB   = 4;  // [5:4] secondary clock source
   localparam int RXC_EN        = 0;
   localparam int TXC_EN        = 0;
   localparam logic [7:0] GPIO_DIR_RESET = 8'h00;
   localparam logic [7:0] REG_RESET      = 8'h00;

   typedef enum logic [1:0] {
      SCP_NRZ  = 2'b00,
      SCP_NRZI = 2'b01,
      SCP_FM0  = 2'b10,
      SCP_FM1  = 2'b11
   } scp_code_t;

   typedef enum logic [1:0] {
      SCP_ASYNC   = 2'b00,
      SCP_EXTSYNC = 2'b01,
      SCP_INTSYNC = 2'b10
   } scp_sync_t;

   typedef enum logic [1:0] {
      SCP_SEC_TXCLK = 2'b00,
      SCP_SEC_BAUD  = 2'b01,
      SCP_SEC_PLL   = 2'b10
   } scp_secsrc_t;

   // Internal CPU bus request
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [31:0] addr;
      logic [31:0] wdata;
   } scp_bus_t;

   // Pin inputs of one channel, active low where the pin is
   typedef struct packed {
      logic rxd;
      logic pri_clk_n;
      logic sec_clk_n;
      logic sync_n;
      logic cts_n;
      logic dcd_n;
   } scp_pins_in_t;
endpackage : scp_pkg

// >>> scp_fifo.sv
// FIFO with valid/ready on both sides
module scp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             flush,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_q;
   logic [AW-1:0]    rp_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem[rp_q];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_q] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else if (flush) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // scp_fifo

// >>> scp_top.sv
// Two-channel serial pin logic with pointer-port register access
module scp_top (
   // Clock and reset
   input  wire logic                     MCLK,
   input  wire logic                     RESET,
   // Internal CPU bus
   input  wire scp_pkg::scp_bus_t        BUS_REQ,
   output logic                   [31:0] BUS_RDATA,
   // Serial pins, index is channel
   input  wire scp_pkg::scp_pins_in_t [1:0] PINS_IN,
   output logic                   [1:0]  SERIAL_TRANSMIT_LINE,
   output logic                   [1:0]  ALT_CLK_OUT,
   output logic                   [1:0]  ALT_CLK_OE,
   output logic                   [1:0]  FRAME_SYNC_OUT,
   output logic                   [1:0]  FRAME_SYNC_OE,
   output logic                   [1:0]  REQUEST_TO_SEND_OUT_N,
   output logic                   [1:0]  TERMINAL_READY_OUT_N,
   // Channel 1 general purpose I/O reuse of one-way pins
   output logic                   [7:0]  GPIO_IN,
   // Core hooks: characters, events
   output logic                   [1:0]  RX_SAMPLE,
   output logic                   [1:0]  RX_BIT,
   output logic                   [1:0]  TX_SHIFT,
   input  wire logic              [1:0]  TX_BIT,
   input  wire logic              [1:0]  SYNC_CHAR_SEEN,
   input  wire logic              [1:0]  PLL_CLK,
   output logic                   [1:0]  FRAME_START,
   output logic                   [1:0]  TX_ENABLE,
   output logic                   [1:0]  RX_ENABLE,
   output logic                   [1:0]  BAUD_CLK_IN,
   // Receive FIFO fill and transmit FIFO drain
   input  wire logic              [1:0]  RXF_VALID,
   output logic                   [1:0]  RXF_READY,
   input  wire logic              [15:0] RXF_DATA,
   output logic                   [1:0]  TXF_VALID,
   input  wire logic              [1:0]  TXF_READY,
   output logic                   [15:0] TXF_DATA
);
   // Register bus decode, bits 1:0 ignored so big-endian +3 hits the same port
   function automatic logic hit(input logic [31:0] a, input logic [31:0] base);
      return a[31:2] == base[31:2];
   endfunction

   logic [7:0] wbyte;
   logic       both_rst;
   logic [1:0] sel_ptr;
   logic [1:0] sel_data;
   logic [7:0] rd_ch [2];

   assign wbyte       = BUS_REQ.wdata[7:0];
   assign both_rst    = BUS_REQ.rd & hit(BUS_REQ.addr, scp_pkg::ADDR_RESET);
   assign sel_ptr[1]  = hit(BUS_REQ.addr, scp_pkg::ADDR_PTR1);
   assign sel_ptr[0]  = hit(BUS_REQ.addr, scp_pkg::ADDR_PTR0);
   assign sel_data[1] = hit(BUS_REQ.addr, scp_pkg::ADDR_DATA1);
   assign sel_data[0] = hit(BUS_REQ.addr, scp_pkg::ADDR_DATA0);

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         BUS_RDATA <= '0;
      end else if (BUS_REQ.rd) begin
         BUS_RDATA <= {24'h000000, (sel_ptr[0] | sel_data[0]) ? rd_ch[0] :
                                   (sel_ptr[1] | sel_data[1]) ? rd_ch[1] : 8'h00};
      end
   end

   logic [7:0] vector_q;
   logic [7:0] gpio_s1_q;
   logic [7:0] gpio_s2_q;

   generate
      for (genvar c = 0; c < 2; c++) begin : g_ch
         scp_pkg::scp_pins_in_t s1_q;
         scp_pkg::scp_pins_in_t s2_q;
         scp_pkg::scp_pins_in_t s3_q;
         logic [3:0] ptr_q;
         logic       armed_q;
         logic [7:0] ien_lo_q;
         logic [7:0] ien_hi_q;
         logic [7:0] rxctl_q;
         logic [7:0] txctl_q;
         logic [7:0] mode_lo_q;
         logic [7:0] mode_hi_q;
         logic [7:0] sync_lo_q;
         logic [7:0] sync_hi_q;
         logic [7:0] clkctl_q;
         logic [7:0] pllctl_q;
         logic [7:0] baud_lo_q;
         logic [7:0] baud_hi_q;
         logic       sync_stat_q;
         logic       sync_out_q;
         logic [1:0] ext_cnt_q;
         logic       txd_q;
         logic       baud_div_q;
         logic       ch_rst;
         logic       wr_ptr;
         logic       rd_ptr;
         logic       ptr_access;
         logic       rx_pop;
         logic       tx_push;
         logic       tx_ready;
         logic       rx_valid;
         logic [7:0] rx_data;
         logic [7:0] rd_int;
         logic [7:0] pending;
         logic       autohs;
         logic       rxe;
         logic       txe;
         logic       rx_fall;
         logic       rx_edge;
         logic       tx_fall;
         logic       tx_edge;
         scp_pkg::scp_code_t code;
         scp_pkg::scp_sync_t smode;
         scp_pkg::scp_secsrc_t ssrc;

         assign code   = scp_pkg::scp_code_t'(mode_lo_q[scp_pkg::MODE_CODE_LSB +: 2]);
         assign smode  = scp_pkg::scp_sync_t'(mode_lo_q[scp_pkg::MODE_SYNC_LSB +: 2]);
         assign ssrc   = scp_pkg::scp_secsrc_t'(clkctl_q[scp_pkg::CLK_SEC_LSB +: 2]);
         assign autohs = mode_lo_q[scp_pkg::MODE_AUTOHS];
         assign ch_rst = both_rst | (BUS_REQ.wr & sel_ptr[c] & armed_q &
                                     (ptr_q == scp_pkg::P_STAT_LO || ptr_q == scp_pkg::P_CHRST));

         // Two-flop pin synchronisers, third stage for edge detect
         always_ff @(posedge MCLK or posedge RESET) begin
            if (RESET) begin
               s1_q <= '1;
               s2_q <= '1;
               s3_q <= '1;
            end else begin
               s1_q <= PINS_IN[c];
               s2_q <= s1_q;
               s3_q <= s2_q;
            end
         end

         // Pointer pairing
         assign wr_ptr     = BUS_REQ.wr & sel_ptr[c];
         assign rd_ptr     = BUS_REQ.rd & sel_ptr[c];
         assign ptr_access = (wr_ptr | rd_ptr) & armed_q;
         always_ff @(posedge MCLK or posedge RESET) begin
            if (RESET) begin
               ptr_q   <= '0;
               armed_q <= 1'b0;
            end else if (ch_rst | ptr_access) begin
               ptr_q   <= '0;
               armed_q <= 1'b0;
            end else if (wr_ptr) begin
               ptr_q   <= wbyte[3:0];
               armed_q <= 1'b1;
            end
         end

         // Internal write registers
         always_ff @(posedge MCLK or posedge RESET) begin
            if (RESET) begin
               {ien_lo_q, ien_hi_q, rxctl_q, txctl_q, mode_lo_q, mode_hi_q} <= {6{scp_pkg::REG_RESET}};
               {sync_lo_q, sync_hi_q, clkctl_q, pllctl_q, baud_lo_q, baud_hi_q} <= {6{scp_pkg::REG_RESET}};
            end else if (ch_rst) begin
               {ien_lo_q, ien_hi_q, rxctl_q, txctl_q, mode_lo_q, mode_hi_q} <= {6{scp_pkg::REG_RESET}};
               {sync_lo_q, sync_hi_q, clkctl_q, pllctl_q, baud_lo_q, baud_hi_q} <= {6{scp_pkg::REG_RESET}};
            end else if (wr_ptr & armed_q) begin
               case (ptr_q)
                  scp_pkg::P_STAT_HI: ien_lo_q  <= wbyte;
                  scp_pkg::P_PEND:    rxctl_q   <= wbyte;
                  scp_pkg::P_MODE_LO: mode_lo_q <= wbyte;
                  scp_pkg::P_TXCTL:   txctl_q   <= wbyte;
                  scp_pkg::P_SYNC_LO: sync_lo_q <= wbyte;
                  scp_pkg::P_SYNC_HI: sync_hi_q <= wbyte;
                  scp_pkg::P_MODE_HI: mode_hi_q <= wbyte;
                  scp_pkg::P_CLKCTL:  clkctl_q  <= wbyte;
                  scp_pkg::P_BAUD_LO: baud_lo_q <= wbyte;
                  scp_pkg::P_BAUD_HI: baud_hi_q <= wbyte;
                  scp_pkg::P_PLLCTL:  pllctl_q  <= wbyte;
                  scp_pkg::P_IEN_HI:  ien_hi_q  <= wbyte;
                  default: ;
               endcase
            end
         end

         // Data FIFOs
         assign rx_pop  = BUS_REQ.rd & (sel_data[c] | (rd_ptr & armed_q & ptr_q == scp_pkg::P_FIFO));
         assign tx_push = BUS_REQ.wr & ((sel_data[c]) | (wr_ptr & armed_q & ptr_q == scp_pkg::P_FIFO));

         scp_fifo #(.WIDTH(scp_pkg::FIFO_WIDTH), .DEPTH(scp_pkg::FIFO_DEPTH)) u_rxf (
            .clk(MCLK), .rst(RESET), .flush(ch_rst),
            .in_valid(RXF_VALID[c]), .in_ready(RXF_READY[c]), .in_data(RXF_DATA[c*8 +: 8]),
            .out_valid(rx_valid), .out_ready(rx_pop), .out_data(rx_data));
         scp_fifo #(.WIDTH(scp_pkg::FIFO_WIDTH), .DEPTH(scp_pkg::FIFO_DEPTH)) u_txf (
            .clk(MCLK), .rst(RESET), .flush(ch_rst),
            .in_valid(tx_push), .in_ready(tx_ready), .in_data(wbyte),
            .out_valid(TXF_VALID[c]), .out_ready(TXF_READY[c] & txe), .out_data(TXF_DATA[c*8 +: 8]));

         // Read decode
         assign pending = {5'h00, TXF_VALID[c], rx_valid, sync_stat_q};
         always_comb begin
            case (ptr_q)
               scp_pkg::P_STAT_LO: rd_int = {1'b0, 1'b0, s2_q.cts_n, sync_stat_q, s2_q.dcd_n,
                                              ~TXF_VALID[c], ~tx_ready, rx_valid};
               scp_pkg::P_STAT_HI: rd_int = {7'h00, ~TXF_VALID[c]};
               scp_pkg::P_VECTOR:  rd_int = (c == 1) ? vector_q : 8'h00;
               scp_pkg::P_PEND:    rd_int = pending & ien_lo_q;
               scp_pkg::P_FIFO:    rd_int = rx_data;
               scp_pkg::P_MODE_HI: rd_int = {5'h00, clkctl_q[2:0]};
               scp_pkg::P_BAUD_LO: rd_int = baud_lo_q;
               scp_pkg::P_BAUD_HI: rd_int = baud_hi_q;
               scp_pkg::P_IEN_HI:  rd_int = ien_hi_q;
               default:            rd_int = 8'h00;
            endcase
         end
         assign rd_ch[c] = sel_data[c] ? rx_data : (armed_q ? rd_int : {4'h0, ptr_q});

         // Handshake enables
         assign txe = txctl_q[scp_pkg::TXC_EN] & (~autohs | ~s2_q.cts_n);
         assign rxe = rxctl_q[scp_pkg::RXC_EN] & (~autohs | ~s2_q.dcd_n);
         assign TX_ENABLE[c] = txe;
         assign RX_ENABLE[c] = rxe;

         always_ff @(posedge MCLK or posedge RESET) begin
            if (RESET) begin
               REQUEST_TO_SEND_OUT_N[c] <= 1'b1;
               TERMINAL_READY_OUT_N[c]  <= 1'b1;
            end else begin
               REQUEST_TO_SEND_OUT_N[c] <= ~(autohs & smode == scp_pkg::SCP_ASYNC & TXF_VALID[c]);
               TERMINAL_READY_OUT_N[c]  <= ~mode_lo_q[scp_pkg::MODE_DTR];
            end
         end

         // Receive sampling: asserting edge of a negated clock is its fall
         assign rx_fall = clkctl_q[scp_pkg::CLK_RX_PRI] ? (s3_q.pri_clk_n & ~s2_q.pri_clk_n)
                                                         : (s3_q.sec_clk_n & ~s2_q.sec_clk_n);
         assign rx_edge = clkctl_q[scp_pkg::CLK_RX_PRI] ? (s3_q.pri_clk_n ^ s2_q.pri_clk_n)
                                                         : (s3_q.sec_clk_n ^ s2_q.sec_clk_n);
         assign RX_SAMPLE[c] = rxe & (code[1] ? rx_edge : (rx_edge & ~rx_fall));
         assign RX_BIT[c]    = s2_q.rxd;

         // Transmit timing on the secondary clock
         assign tx_fall = s3_q.sec_clk_n & ~s2_q.sec_clk_n;
         assign tx_edge = s3_q.sec_clk_n ^ s2_q.sec_clk_n;
         assign TX_SHIFT[c] = txe & clkctl_q[scp_pkg::CLK_TX_SEC] &
                              (code[1] ? tx_edge : (tx_edge & ~tx_fall));
         always_ff @(posedge MCLK or posedge RESET) begin
            if (RESET) begin
               txd_q <= 1'b1;
            end else if (TX_SHIFT[c] | ~clkctl_q[scp_pkg::CLK_TX_SEC]) begin
               txd_q <= txe ? TX_BIT[c] : 1'b1;
            end
         end
         assign SERIAL_TRANSMIT_LINE[c] = txd_q;

         // Baud input: system clock enable or primary clock
         always_ff @(posedge MCLK or posedge RESET) begin
            if (RESET) begin
               baud_div_q <= 1'b0;
            end else begin
               baud_div_q <= clkctl_q[scp_pkg::CLK_BAUD_SYS] ? ~baud_div_q : ~s2_q.pri_clk_n;
            end
         end
         assign BAUD_CLK_IN[c] = baud_div_q;

         // Secondary clock as active-low output
         assign ALT_CLK_OE[c] = clkctl_q[scp_pkg::CLK_SEC_OUT];
         always_comb begin
            case (ssrc)
               scp_pkg::SCP_SEC_TXCLK: ALT_CLK_OUT[c] = ~baud_div_q;
               scp_pkg::SCP_SEC_BAUD:  ALT_CLK_OUT[c] = s2_q.pri_clk_n;
               scp_pkg::SCP_SEC_PLL:   ALT_CLK_OUT[c] = ~PLL_CLK[c];
               default:                ALT_CLK_OUT[c] = 1'b1;
            endcase
         end

         // Sync pin modes
         always_ff @(posedge MCLK or posedge RESET) begin
            if (RESET) begin
               sync_stat_q <= 1'b0;
               sync_out_q  <= 1'b1;
               ext_cnt_q   <= '0;
               FRAME_START[c] <= 1'b0;
            end else begin
               sync_stat_q <= ~s2_q.sync_n;
               sync_out_q  <= ~(smode == scp_pkg::SCP_INTSYNC & SYNC_CHAR_SEEN[c]);
               if (smode == scp_pkg::SCP_EXTSYNC & ~s2_q.sync_n) begin
                  ext_cnt_q <= (ext_cnt_q == 2'd2) ? ext_cnt_q : ext_cnt_q + 2'd1;
               end else begin
                  ext_cnt_q <= '0;
               end
               FRAME_START[c] <= (ext_cnt_q == 2'd1) & ~s2_q.sync_n &
                                 (smode == scp_pkg::SCP_EXTSYNC);
            end
         end
         assign FRAME_SYNC_OUT[c] = sync_out_q;
         assign FRAME_SYNC_OE[c]  = (smode == scp_pkg::SCP_INTSYNC);
      end
   endgenerate

   // Channel 1 vector; pointer 0x02 writes on channel 0 are dropped
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         vector_q <= '0;
      end else if (both_rst) begin
         vector_q <= '0;
      end else if (BUS_REQ.wr & sel_ptr[1] & g_ch[1].armed_q & g_ch[1].ptr_q == scp_pkg::P_VECTOR) begin
         vector_q <= {5'h00, wbyte[2:0]};
      end
   end

   // Channel 1 one-way pins also readable as general purpose inputs
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         gpio_s1_q <= scp_pkg::GPIO_DIR_RESET;
         gpio_s2_q <= scp_pkg::GPIO_DIR_RESET;
      end else begin
         gpio_s1_q <= {2'b00, PINS_IN[1]};
         gpio_s2_q <= gpio_s1_q;
      end
   end
   assign GPIO_IN = gpio_s2_q;
endmodule // scp_top

// >>> scp_top_properties.sv
// Port assertions for the serial pin and pointer block
module scp_top_properties (
   // Clock, reset, bus
   input wire logic              MCLK,
   input wire logic              RESET,
   input wire scp_pkg::scp_bus_t BUS_REQ,
   input wire logic [31:0]       BUS_RDATA,
   // Pins and drain side
   input wire logic [1:0]        FRAME_SYNC_OUT,
   input wire logic [1:0]        FRAME_SYNC_OE,
   input wire logic [1:0]        REQUEST_TO_SEND_OUT_N,
   input wire logic [1:0]        TERMINAL_READY_OUT_N,
   input wire logic [1:0]        TX_ENABLE,
   input wire logic [1:0]        TXF_VALID,
   input wire logic [1:0]        TXF_READY
);
   logic wp0, wp1;
   assign wp0 = BUS_REQ.wr && BUS_REQ.addr == scp_pkg::ADDR_PTR0;
   assign wp1 = BUS_REQ.wr && BUS_REQ.addr == scp_pkg::ADDR_PTR1;
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RESET);
   upper_zero_a: assert property (BUS_RDATA[31:8] == 24'h0) else $error("upper bytes set");
   sync_low_a: assert property (FRAME_SYNC_OE == 2'b00 |=> FRAME_SYNC_OUT == 2'b11) else $error("sync driven low");
   vector_zero_a: assert property (wp0 && BUS_REQ.wdata[7:0] == 8'h02 ##2 BUS_REQ.rd &&
      BUS_REQ.addr == scp_pkg::ADDR_PTR0 |=> BUS_RDATA == 32'h0) else $error("vector not zero");
   ptr_return_a: assert property (wp1 ##2 wp1 ##2 BUS_REQ.rd &&
      BUS_REQ.addr == scp_pkg::ADDR_PTR1 |=> BUS_RDATA == 32'h0) else $error("pointer kept");
   dtr_follow_a: assert property (wp0 && BUS_REQ.wdata[7:0] == 8'h04 ##2 wp0 && BUS_REQ.wdata[5]
      |-> ##[1:2] !TERMINAL_READY_OUT_N[0]) else $error("ready not low");
   chan_reset_a: assert property (BUS_REQ.rd && BUS_REQ.addr == scp_pkg::ADDR_RESET
      |-> ##[1:3] (TERMINAL_READY_OUT_N & REQUEST_TO_SEND_OUT_N) == 2'b11) else $error("no reset");
   tx_load_a: assert property (BUS_REQ.wr && BUS_REQ.addr == scp_pkg::ADDR_DATA0 && TX_ENABLE[0]
      |-> ##[1:3] TXF_VALID[0]) else $error("byte not queued");
   tx_hold_a: assert property (!TX_ENABLE[1] && TXF_VALID[1] && TXF_READY[1] |=> TXF_VALID[1])
      else $error("drained while disabled");
   cover property (TXF_VALID[0] && TXF_READY[0]);
   cover property ($rose(TX_ENABLE[1]));
   cover property ($fell(TERMINAL_READY_OUT_N[1]));
   cover property (FRAME_SYNC_OE[0] && !FRAME_SYNC_OUT[0]);
endmodule // scp_top_properties

bind scp_top scp_top_properties u_scp_top_properties (.MCLK, .RESET, .BUS_REQ, .BUS_RDATA, .FRAME_SYNC_OUT,
   .FRAME_SYNC_OE, .REQUEST_TO_SEND_OUT_N, .TERMINAL_READY_OUT_N, .TX_ENABLE, .TXF_VALID, .TXF_READY);

// >>> scp_modem.sv
// Line transceiver model on the serial pins of both channels
module scp_modem (
   input wire logic clk,
   // Bench commands per channel
   input wire logic [1:0] run,
   input wire logic [1:0] cts_n,
   input wire logic [1:0] dcd_n,
   input wire logic [1:0] sync_req,
   // Device pin inputs
   output wire scp_pkg::scp_pins_in_t [1:0] pins
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] div_q [2] = '{3'h0, 3'h0};
   logic [1:0] hold_q [2] = '{2'h0, 2'h0};
   logic [1:0] rxd_q = 2'b00;
   for (genvar c = 0; c < 2; c++) begin : g_ch
      // Clocks stand outside frames; released data line toggles
      always @(posedge clk) begin
         div_q[c] <= run[c] ? div_q[c] + 3'h1 : 3'h0;
         rxd_q[c] <= run[c] ? div_q[c][1] : ~rxd_q[c];
         hold_q[c] <= sync_req[c] ? 2'h2 : hold_q[c] - {1'b0, |hold_q[c]};
      end
      assign pins[c] = {rxd_q[c], ~run[c] | div_q[c][2], ~run[c] | div_q[c][2], ~|hold_q[c], cts_n[c], dcd_n[c]};
   end
endmodule // scp_modem

// >>> test_scp_top.sv
// Self-checking bench for the serial pin and pointer block
module test_scp_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, rst = 1'b1;
   scp_pkg::scp_bus_t req = '0;
   scp_pkg::scp_pins_in_t [1:0] pins;
   logic [31:0] rdata, d;
   logic [15:0] txf_d, rxf_d = 16'h0;
   logic [1:0] dtr_n, rts_n, txe, rxe, txf_v, rxf_r, fso, fsoe;
   logic [1:0] txf_r = 2'b00, rxf_v = 2'b00, run = 2'b00, cts_n = 2'b11, dcd_n = 2'b11, sreq = 2'b00, seen = 2'b00;
   int fails = 0, num_checks = 0, n;
   scp_top u_scp_top (.MCLK(clk), .RESET(rst), .BUS_REQ(req), .BUS_RDATA(rdata), .PINS_IN(pins),
      .SERIAL_TRANSMIT_LINE(), .ALT_CLK_OUT(), .ALT_CLK_OE(), .FRAME_SYNC_OUT(fso), .FRAME_SYNC_OE(fsoe),
      .REQUEST_TO_SEND_OUT_N(rts_n), .TERMINAL_READY_OUT_N(dtr_n), .GPIO_IN(), .RX_SAMPLE(), .RX_BIT(),
      .TX_SHIFT(), .TX_BIT(2'b00), .SYNC_CHAR_SEEN(seen), .PLL_CLK(2'b00), .FRAME_START(), .TX_ENABLE(txe),
      .RX_ENABLE(rxe), .BAUD_CLK_IN(), .RXF_VALID(rxf_v), .RXF_READY(rxf_r), .RXF_DATA(rxf_d),
      .TXF_VALID(txf_v), .TXF_READY(txf_r), .TXF_DATA(txf_d));
   scp_modem u_scp_modem (.clk(clk), .run(run), .cts_n(cts_n), .dcd_n(dcd_n), .sync_req(sreq), .pins(pins));
   always #2 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // One request cycle, then one idle cycle; upper lanes carry junk
   task automatic acc(input logic r, input logic [31:0] a, input logic [7:0] v);
      req = '{rd: r, wr: !r, addr: a, wdata: {24'ha5a5a5, v}};
      @(posedge clk);
      #1 req = '0;
      @(posedge clk);
      #1 d = rdata;
   endtask
   task automatic wreg(input int c, input logic [3:0] p, input logic [7:0] v);
      @(posedge clk);
      #1 acc(0, c ? scp_pkg::ADDR_PTR1 : scp_pkg::ADDR_PTR0, {4'h0, p});
      acc(0, c ? scp_pkg::ADDR_PTR1 : scp_pkg::ADDR_PTR0, v);
   endtask
   task automatic t_ptr;
      acc(0, scp_pkg::ADDR_PTR0, 8'h02);
      acc(1, scp_pkg::ADDR_PTR0, 8'h00);
      chk(d, 32'h0);
      wreg(1, scp_pkg::P_SYNC_LO, 8'h7e);
      acc(1, scp_pkg::ADDR_PTR1, 8'h00);
      chk(d, 32'h0);
      wreg(0, scp_pkg::P_CLKCTL, 8'h05);
      acc(0, scp_pkg::ADDR_PTR0, 8'h0a);
      acc(1, scp_pkg::ADDR_PTR0, 8'h00);
      chk(d, 32'h5);
   endtask
   task automatic t_dtr;
      wreg(0, scp_pkg::P_MODE_LO, 8'h20);
      wreg(1, scp_pkg::P_MODE_LO, 8'h20);
      #8 chk(dtr_n, 2'b00);
      acc(1, scp_pkg::ADDR_RESET, 8'h00);
      #8 chk({rts_n, dtr_n}, 4'hf);
   endtask
   task automatic t_fifo;
      wreg(0, scp_pkg::P_TXCTL, 8'h01);
      wreg(0, 4'h3, 8'h01);
      for (int i = 0; i < 17; i++) acc(0, scp_pkg::ADDR_DATA0, 8'h40 + i[7:0]);
      txf_r[0] = 1'b1;
      n = 0;
      for (int k = 0; k < 60 && n < 17; k++) begin
         @(negedge clk);
         if (txf_v[0] === 1'b1) begin
            chk(txf_d[7:0], 8'h40 + n[7:0]);
            n++;
         end
      end
      chk(n, 16);
      @(posedge clk);
      #1 chk(rxf_r[0], 1'b1);
      rxf_v[0] = 1'b1;
      rxf_d[7:0] = 8'hc1;
      @(posedge clk);
      #1 rxf_d[7:0] = 8'hc2;
      @(posedge clk);
      #1 rxf_v[0] = 1'b0;
      acc(0, scp_pkg::ADDR_PTR0, {4'h0, scp_pkg::P_FIFO});
      acc(1, scp_pkg::ADDR_DATA0, 8'h00);
      chk(d, 32'hc1);
      acc(1, scp_pkg::ADDR_PTR0, 8'h00);
      chk(d, 32'hc2);
   endtask
   task automatic t_sync;
      wreg(0, scp_pkg::P_MODE_LO, 8'h08);
      seen[0] = 1'b1;
      #4 seen[0] = 1'b0;
      chk({fsoe[0], fso[0]}, 2'b10);
      #4 chk(fso[0], 1'b1);
   endtask
   task automatic t_hs;
      txf_r[1] = 1'b1;
      run[1] = 1'b1;
      sreq[1] = 1'b1;
      wreg(1, scp_pkg::P_MODE_LO, 8'h10);
      sreq[1] = 1'b0;
      wreg(1, scp_pkg::P_TXCTL, 8'h01);
      wreg(1, 4'h3, 8'h01);
      acc(0, scp_pkg::ADDR_DATA1, 8'h5a);
      chk({txe[1], rxe[1], rts_n[1]}, 3'b000);
      cts_n[1] = 1'b0;
      dcd_n[1] = 1'b0;
      for (n = 0; n < 20 && rts_n[1] !== 1'b1; n++) #4;
      chk({txe[1], rxe[1], rts_n[1]}, 3'b111);
      if (n >= 20) conclude();
   endtask
   initial begin
      repeat (10) @(posedge clk);
      #1 rst = 1'b0;
      t_ptr();
      t_dtr();
      t_fifo();
      t_sync();
      t_hs();
      conclude();
   end
endmodule // test_scp_top
